// >>> va_check_consts.svh
// Constants for the virtual address segment check.
// Assumes inclusion by bare name from the decoder, the check and the bench.
`ifndef VA_CHECK_CONSTS_SVH
`define VA_CHECK_CONSTS_SVH

// ------------------------------------------------------------
// Address geometry
// ------------------------------------------------------------
`define VA_SIZE          43
`define PA_SIZE          (`VA_SIZE - 2)
`define PAGE_OFFSET_BITS 13
`define PAGE_KBYTES      8
`define PAGE_KBYTES_MIN  8
`define PAGE_KBYTES_MAX  64

// ------------------------------------------------------------
// Segment select patterns
// ------------------------------------------------------------
`define SEL_KERNEL_DIRECT 2'h2
`define SEL_HIGH_MAPPED   2'h3

`endif

// >>> va_check_pkg.sv
// Types shared by the address check and its decoder.
// Assumes nothing of its surroundings.
package va_check_pkg;

   // Segment chosen by the two select bits
   typedef enum logic [1:0] {
      SEG_LOW_MAPPED,
      SEG_KERNEL_DIRECT,
      SEG_HIGH_MAPPED
   } segment_t;

   // Kind of access being checked
   typedef enum logic [1:0] {
      ACC_READ,
      ACC_WRITE,
      ACC_FETCH
   } access_t;

   // Privilege level, kernel is the more privileged
   typedef enum logic {
      MODE_KERNEL,
      MODE_USER
   } mode_t;

endpackage

// >>> va_range_decode.sv
// Combinational sign-extension check and segment decode.
// Assumes a 64-bit address from logic on the same clock.
`include "va_check_consts.svh"

module va_range_decode (
   // Address in
   input  wire logic [63:0]            vaddr,
   // Decode out
   output logic                        inRange,
   output va_check_pkg::segment_t      segment
);

   localparam int VA = `VA_SIZE;

   // ------------------------------------------------------------
   // Range and segment
   // ------------------------------------------------------------

   // All bits above the width must copy the top implemented bit
   always_comb begin
      inRange = (&vaddr[63:VA-1]) | ~(|vaddr[63:VA-1]);
      case (vaddr[VA-1:VA-2])
         `SEL_KERNEL_DIRECT: segment = va_check_pkg::SEG_KERNEL_DIRECT;
         `SEL_HIGH_MAPPED:   segment = va_check_pkg::SEG_HIGH_MAPPED;
         default:            segment = va_check_pkg::SEG_LOW_MAPPED;
      endcase
   end

endmodule

// >>> virtual_address_segment_check.sv
// Virtual address range check, segment decode and page protection.
// Assumes requests, mode and page protection bits come from logic on sys_clk.
`include "va_check_consts.svh"

// Functional notes
// - Width is 43, 47, 51 or 55 bits
// - Upper bits must equal top implemented bit
// - Out-of-range address raises access violation
// - Select bits choose low, kernel, high segment
// - Kernel segment: direct address, kernel only
// - Mapped segments use per-page protection, 8-64K
// - Two privilege levels: kernel and user
// - User pages: none, read, read/write; data/instr
// - Direct address is bits width-3 down to 0
// - Physical address is width minus two bits
// - Page offset is 13 to 16 bits
module virtual_address_segment_check (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     resetn,
   // Address generation side
   input  wire logic                     reqValid,
   input  wire logic [63:0]              vaddr,
   input  wire va_check_pkg::access_t    accKind,
   input  wire va_check_pkg::mode_t      privMode,
   // Page protection from the translation buffer
   input  wire logic                     pageKre,
   input  wire logic                     pageKwe,
   input  wire logic                     pageUre,
   input  wire logic                     pageUwe,
   input  wire logic                     pageFoe,
   input  wire logic                     pageFor,
   input  wire logic                     pageFow,
   // Result
   output logic                          rspValid,
   output logic                          accViol,
   output logic                          useFault,
   output va_check_pkg::segment_t        segment,
   // Memory path side
   output logic                          translateReq,
   output logic [63:0]                   translateAddr,
   output logic                          physReq,
   output logic [`PA_SIZE-1:0]           physAddr
);

   localparam int VA = `VA_SIZE;
   localparam int PA = `PA_SIZE;

   // Legal widths and page geometry, fixed at elaboration
   localparam bit WidthOk  = (VA == 43) || (VA == 47) || (VA == 51) || (VA == 55);
   localparam bit OffsetOk = (`PAGE_OFFSET_BITS >= 13) && (`PAGE_OFFSET_BITS <= 16);
   localparam bit PageOk   = (`PAGE_KBYTES >= `PAGE_KBYTES_MIN) && (`PAGE_KBYTES <= `PAGE_KBYTES_MAX)
                             && ((1 << `PAGE_OFFSET_BITS) == `PAGE_KBYTES * 1024);
   localparam bit PaOk     = (PA == VA - 2);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Page permission for the given mode and access
   function automatic logic prot_allows(input va_check_pkg::mode_t m, input va_check_pkg::access_t a,
                                        input logic kre, input logic kwe, input logic ure, input logic uwe);
      logic re;
      logic we;
      re = (m == va_check_pkg::MODE_KERNEL) ? kre : ure;
      we = (m == va_check_pkg::MODE_KERNEL) ? kwe : uwe;
      prot_allows = (a == va_check_pkg::ACC_WRITE) ? we : re;
   endfunction

   // ------------------------------------------------------------
   // Same-cycle decision
   // ------------------------------------------------------------
   logic                   inRange;
   va_check_pkg::segment_t segNow;
   logic                   mappedNow;
   logic                   acvNow;
   logic                   useNow;

   va_range_decode u_decode (
      .vaddr   (vaddr),
      .inRange (inRange),
      .segment (segNow)
   );

   // Violation outranks the use faults
   always_comb begin
      mappedNow = (segNow != va_check_pkg::SEG_KERNEL_DIRECT);
      acvNow    = !inRange;
      if (inRange && !mappedNow && privMode == va_check_pkg::MODE_USER) begin
         acvNow = 1'b1;
      end
      if (inRange && mappedNow && !prot_allows(privMode, accKind, pageKre, pageKwe, pageUre, pageUwe)) begin
         acvNow = 1'b1;
      end
      // Data-only and instruction-only pages
      useNow = !acvNow && mappedNow &&
               ((accKind == va_check_pkg::ACC_FETCH && pageFoe) ||
                (accKind == va_check_pkg::ACC_READ  && pageFor) ||
                (accKind == va_check_pkg::ACC_WRITE && pageFow));
   end

   // ------------------------------------------------------------
   // Registered result
   // ------------------------------------------------------------

   // Status of each checked request
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rspValid <= 1'b0;
         accViol  <= 1'b0;
         useFault <= 1'b0;
         segment  <= va_check_pkg::SEG_LOW_MAPPED;
      end else begin
         rspValid <= reqValid;
         accViol  <= reqValid && acvNow;
         useFault <= reqValid && useNow;
         segment  <= reqValid ? segNow : va_check_pkg::SEG_LOW_MAPPED;
      end
   end

   // Hand-off to translation for mapped segments
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         translateReq  <= 1'b0;
         translateAddr <= 64'h0000_0000_0000_0000;
      end else begin
         translateReq  <= reqValid && mappedNow && !acvNow && !useNow;
         translateAddr <= (reqValid && mappedNow && !acvNow && !useNow) ? vaddr : 64'h0000_0000_0000_0000;
      end
   end

   // Direct physical address for the kernel segment
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         physReq  <= 1'b0;
         physAddr <= '0;
      end else begin
         physReq  <= reqValid && !mappedNow && !acvNow;
         physAddr <= (reqValid && !mappedNow && !acvNow) ? vaddr[PA-1:0] : '0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_width_legal: assert property (@(posedge sys_clk) disable iff (!resetn) WidthOk && PaOk)
      else $error("address width not a legal size");

   a_page_geometry: assert property (@(posedge sys_clk) disable iff (!resetn) OffsetOk && PageOk)
      else $error("page offset or page size out of range");

   a_range_fault: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && !((&vaddr[63:VA-1]) || !(|vaddr[63:VA-1])) |=> rspValid && accViol)
      else $error("bad sign extension not flagged");

   a_fault_no_mem: assert property (@(posedge sys_clk) disable iff (!resetn)
      accViol |-> !physReq && !translateReq)
      else $error("request issued despite violation");

   a_kernel_direct: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && inRange && vaddr[VA-1:VA-2] == 2'h2 && privMode == va_check_pkg::MODE_KERNEL
      |=> physReq && !accViol && physAddr == $past(vaddr[PA-1:0]))
      else $error("kernel direct address wrong");

   a_user_kernel: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && privMode == va_check_pkg::MODE_USER && vaddr[VA-1:VA-2] == 2'h2
      |=> accViol && !physReq && segment == va_check_pkg::SEG_KERNEL_DIRECT)
      else $error("user access to kernel segment allowed");

   a_mapped_xlate: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && inRange && vaddr[VA-1:VA-2] != 2'h2 && !acvNow && !useNow
      |=> translateReq && !physReq && translateAddr == $past(vaddr))
      else $error("mapped access not sent to translation");

   a_user_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && inRange && vaddr[VA-1:VA-2] != 2'h2 && privMode == va_check_pkg::MODE_USER
      && accKind == va_check_pkg::ACC_WRITE && !pageUwe |=> accViol && !useFault)
      else $error("user write to read-only page allowed");

   a_data_only: assert property (@(posedge sys_clk) disable iff (!resetn)
      useFault |-> !accViol && !translateReq && $past(reqValid))
      else $error("use fault with other outcome");

   a_one_cycle: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid ##1 !reqValid |=> !rspValid && !accViol && !physReq && !translateReq)
      else $error("result outlives its request");

   // ------------------------------------------------------------
   // Segment, protection and idle outcomes
   // ------------------------------------------------------------
   a_high_segment: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && vaddr[VA-1:VA-2] == 2'h3 |=> segment == va_check_pkg::SEG_HIGH_MAPPED)
      else $error("high segment not decoded");

   a_low_segment: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && !vaddr[VA-1] |=> segment == va_check_pkg::SEG_LOW_MAPPED)
      else $error("low segment not decoded");

   a_range_pass: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && vaddr[63:VA-1] == '0 && privMode == va_check_pkg::MODE_KERNEL
      && accKind == va_check_pkg::ACC_READ && pageKre && !pageFor |=> !accViol && translateReq)
      else $error("valid low address refused");

   a_user_read: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && inRange && vaddr[VA-1:VA-2] != 2'h2 && privMode == va_check_pkg::MODE_USER
      && accKind != va_check_pkg::ACC_WRITE && !pageUre |=> accViol && !translateReq)
      else $error("user read of closed page allowed");

   a_kernel_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && inRange && vaddr[VA-1:VA-2] != 2'h2 && privMode == va_check_pkg::MODE_KERNEL
      && accKind == va_check_pkg::ACC_WRITE && !pageKwe |=> accViol && !translateReq)
      else $error("kernel write to read-only page allowed");

   a_kernel_read: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && inRange && vaddr[VA-1:VA-2] != 2'h2 && privMode == va_check_pkg::MODE_KERNEL
      && accKind != va_check_pkg::ACC_WRITE && !pageKre |=> accViol && !translateReq)
      else $error("kernel read of closed page allowed");

   a_fetch_fault: assert property (@(posedge sys_clk) disable iff (!resetn)
      reqValid && inRange && vaddr[VA-1:VA-2] != 2'h2 && accKind == va_check_pkg::ACC_FETCH
      && pageFoe && !acvNow |=> useFault && !translateReq)
      else $error("fetch from data-only page allowed");

   a_fault_rank: assert property (@(posedge sys_clk) disable iff (!resetn)
      accViol |-> !useFault)
      else $error("use fault beside access violation");

   a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
      !reqValid |=> !rspValid && !accViol && !useFault && !physReq && !translateReq)
      else $error("result without a request");

endmodule

// >>> page_table_model.sv
// Page protection model standing in for the translation buffer.
// Assumes the address arrives from the bench on the same clock.
module page_table_model (
   // Address in
   input  wire logic [63:0] vaddr,
   // Protection out
   output logic             pageKre,
   output logic             pageKwe,
   output logic             pageUre,
   output logic             pageUwe,
   output logic             pageFoe,
   output logic             pageFor,
   output logic             pageFow
);
   timeunit 1ns;
   timeprecision 1ps;
   // Page number above the 13-bit offset picks the bits
   assign {pageFow, pageFor, pageFoe, pageUwe, pageUre, pageKwe, pageKre} = vaddr[19:13];
endmodule

// >>> tb_top.sv
// Self-checking bench for the virtual address segment check.
// Assumes the design files and the page table model are compiled first.
`include "va_check_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals and expected-side record
   // ------------------------------------------------------------
   logic sys_clk = 0, resetn = 0, reqValid = 0;
   logic [63:0] vaddr = '0, pa = '0, translateAddr;
   va_check_pkg::access_t accKind = va_check_pkg::ACC_READ, pk;
   va_check_pkg::mode_t privMode = va_check_pkg::MODE_KERNEL, pm;
   va_check_pkg::segment_t segment;
   logic pageKre, pageKwe, pageUre, pageUwe, pageFoe, pageFor, pageFow;
   logic rspValid, accViol, useFault, translateReq, physReq, pv = 0;
   logic [`PA_SIZE-1:0] physAddr;
   logic [6:0] pg = '0;
   logic [63:0] corner [8] = '{64'h0000_03FF_FFFF_FFFF, 64'h0000_0400_0000_0000,
      64'hFFFF_FC00_0000_0010, 64'hFFFF_FBFF_FFFF_FFFF, 64'hFFFF_FE00_0000_0000,
      64'h8000_0000_0000_0000, 64'h0000_0000_000F_E000, 64'h0000_0000_0000_0000};
   int err_total = 0, checked = 0;
   logic [63:0] r;

   always #2 sys_clk = ~sys_clk;

   virtual_address_segment_check dut (.sys_clk(sys_clk), .resetn(resetn), .reqValid(reqValid),
      .vaddr(vaddr), .accKind(accKind), .privMode(privMode), .pageKre(pageKre), .pageKwe(pageKwe),
      .pageUre(pageUre), .pageUwe(pageUwe), .pageFoe(pageFoe), .pageFor(pageFor), .pageFow(pageFow),
      .rspValid(rspValid), .accViol(accViol), .useFault(useFault), .segment(segment),
      .translateReq(translateReq), .translateAddr(translateAddr), .physReq(physReq),
      .physAddr(physAddr));
   page_table_model ptm (.vaddr(vaddr), .pageKre(pageKre), .pageKwe(pageKwe), .pageUre(pageUre),
      .pageUwe(pageUwe), .pageFoe(pageFoe), .pageFor(pageFor), .pageFow(pageFow));

   // ------------------------------------------------------------
   // Compare, expect and drive
   // ------------------------------------------------------------
   task automatic comp(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("ERROR %0t: %s mismatch", $time, what);
      end
   endtask

   // Result of the previous request, worked out from its inputs
   task automatic check_rsp();
      logic inR, ks, usr, ok, viol, uf, tr;
      va_check_pkg::segment_t seg;
      inR = (pa[63:42] == '0) || (pa[63:42] == '1);
      ks = pa[42:41] == 2'b10;
      usr = pm == va_check_pkg::MODE_USER;
      ok = (pk != va_check_pkg::ACC_WRITE) ? pg[usr ? 2 : 0] : pg[usr ? 3 : 1];
      viol = !inR || (ks && usr) || (!ks && !ok);
      uf = !viol && !ks && pg[pk == va_check_pkg::ACC_FETCH ? 4 : pk == va_check_pkg::ACC_READ ? 5 : 6];
      tr = pv && !ks && !viol && !uf;
      seg = ks ? va_check_pkg::SEG_KERNEL_DIRECT : pa[42] ? va_check_pkg::SEG_HIGH_MAPPED
                                                          : va_check_pkg::SEG_LOW_MAPPED;
      comp(rspValid === pv, "rspValid");
      comp(accViol === (pv && viol), "accViol");
      comp(useFault === (pv && uf), "useFault");
      comp(segment === (pv ? seg : va_check_pkg::SEG_LOW_MAPPED), "segment");
      comp(physReq === (pv && ks && !viol), "physReq");
      comp(physAddr === ((pv && ks && !viol) ? pa[40:0] : '0), "physAddr");
      comp(translateReq === tr, "translateReq");
      comp(translateAddr === (tr ? pa : '0), "translateAddr");
   endtask

   task automatic put(input logic v, input logic [63:0] a, input int k, input int m);
      @(negedge sys_clk);
      check_rsp();
      reqValid = v;
      vaddr = a;
      accKind = va_check_pkg::access_t'(k);
      privMode = va_check_pkg::mode_t'(m);
      #1;
      pv = v;
      pa = a;
      pk = accKind;
      pm = privMode;
      pg = {pageFow, pageFor, pageFoe, pageUwe, pageUre, pageKwe, pageKre};
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hca9f_8a47));
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1;
      // Boundaries back to back, every kind and mode
      foreach (corner[i])
         for (int j = 0; j < 6; j++)
            put(1'b1, corner[i], j % 3, j / 3);
      // Random traffic with idle gaps and broken sign extension
      for (int n = 0; n < 3000; n++) begin
         r = {$urandom, $urandom};
         r = {{21{r[42]}}, r[42:0]};
         if ($urandom % 8 == 0) r[43 + $urandom % 21] = ~r[42];
         put(($urandom % 5) != 0, r, $urandom % 3, $urandom % 2);
      end
      // Reset dropped on a pending request clears every result
      put(1'b1, 64'hFFFF_FC00_0000_0010, 0, 0);
      resetn = 0;
      repeat (2) @(negedge sys_clk);
      comp(!rspValid && !accViol && !useFault && !physReq && !translateReq, "reset clear");
      reqValid = 0;
      pv = 0;
      resetn = 1;
      put(1'b0, '0, 0, 0);
      put(1'b0, '0, 0, 0);
      test_done();
   end

   initial begin
      #20000;
      err_total++;
      test_done();
   end
endmodule
